// ===== rtl/csc_pkg.sv
package csc_pkg;
    localparam logic [7:0] ADDR_C2_TMO = 8'hB8;
    localparam logic [7:0] ADDR_C3_CTL = 8'hBA;
    localparam logic [7:0] ADDR_C3_TMO = 8'hBB;
    localparam logic [7:0] ADDR_C3_LP = 8'hBC;
    localparam logic [7:0] ADDR_STATUS = 8'hC0;
    localparam logic [7:0] ADDR_MASK = 8'hC1;
    localparam logic [7:0] ADDR_SEQ = 8'hC2;
    localparam int FRESP_HI = 15;
    localparam int FRESP_LO = 14;
    localparam int ENSLOT_HI = 13;
    localparam int ENSLOT_LO = 10;
    localparam int SDSLOT_HI = 9;
    localparam int SDSLOT_LO = 6;
    localparam int OVP_OFF_BIT = 11;
    localparam int FLOAT_BIT = 10;
    localparam int VSEL_HI = 6;
    localparam int SLEEP_HI = 14;
    localparam int SLEEP_LO = 12;
    localparam int TRIG_HI = 9;
    localparam int TRIG_LO = 8;
    localparam logic [15:0] C2_TMO_RST = 16'h0000;
    localparam logic [15:0] C3_CTL_RST = 16'h0000;
    localparam logic [15:0] C3_TMO_RST = 16'h0000;
    localparam logic [15:0] C3_LP_RST = 16'h0006;
    localparam logic [15:0] C2_TMO_MASK = 16'hFFC0;
    localparam logic [15:0] C3_CTL_MASK = 16'h0C7F;
    localparam logic [15:0] C3_TMO_MASK = 16'hFFC0;
    localparam logic [15:0] C3_LP_MASK = 16'h737F;
    localparam logic [6:0] VSEL_MAX = 7'h66;
    localparam logic [3:0] SLOT_NONE = 4'h0;
    localparam logic [3:0] SLOT_FIRST = 4'h1;
    localparam logic [3:0] SLOT_LAST = 4'hE;
    localparam logic [3:0] SLOT_EDGE = 4'hF;
    localparam logic [1:0] FR_IGNORE = 2'h0;
    localparam logic [1:0] FR_CONV = 2'h1;
    localparam int SLOT_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam logic [3:0] SL_IMAGE = 4'h1;
    localparam logic [2:0] SB_KEEP = 3'h0;
    localparam logic [2:0] SB_IMAGE = 3'h1;
    localparam logic [2:0] SB_STBY = 3'h2;
    localparam logic [2:0] SB_STBY_IMG = 3'h3;
    localparam logic [2:0] SB_LIN = 3'h4;
    localparam logic [2:0] SB_LIN_IMG = 3'h5;
    localparam logic [2:0] SB_OFF = 3'h7;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_UP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_DOWN = 3'b011
    } csc_state_type;
endpackage

// ===== rtl/csc_top.sv
`timescale 1ns/1ps
module csc_top (
    input wire logic mclk, // 100 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic sm_reset, // Power state machine field reset pulse
    input wire logic power_up_req, // Pulse: begin start-up sequence
    input wire logic power_down_req, // Pulse: begin shutdown sequence
    input wire logic [7:0] addr, // Register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata, // Read data, cycle after rd
    input wire logic conv2_fault, // Converter 2 fault level
    input wire logic conv3_fault, // Converter 3 fault level
    input wire logic sw_sleep, // Software hibernate register bit
    input wire logic low_power_input_1, // Low-power input 1
    input wire logic low_power_input_2, // Low-power input 2
    input wire logic low_power_input_3, // Low-power input 3
    input wire logic gpio_sleep, // GPIO configured as hibernate input
    output logic conv2_en, // Converter 2 enable
    output logic conv3_en, // Converter 3 enable
    output logic conv3_discharge, // Discharge conv 3 output while off
    output logic conv3_ovp_en, // Over-voltage protection active
    output logic [6:0] conv3_vout_code, // Applied voltage code
    output logic conv3_standby, // Force standby mode
    output logic conv3_linear, // Force linear regulator mode
    output logic system_shutdown, // Pulse: request whole-system shutdown
    output logic irq, // Interrupt, level high
    output logic [2:0] seq_state // Sequencer state
);
    logic [15:0] c2_tmo_r, c2_tmo_nxt, c3_ctl_r, c3_ctl_nxt;
    logic [15:0] c3_tmo_r, c3_tmo_nxt, c3_lp_r, c3_lp_nxt;
    logic [1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    csc_pkg::csc_state_type st_r, st_nxt;
    logic [3:0] slot_r, slot_nxt;
    logic [15:0] tick_r, tick_nxt;
    logic c2_en_r, c2_en_nxt, c3_en_r, c3_en_nxt;
    logic c2_ok_r, c2_ok_nxt, c3_ok_r, c3_ok_nxt;
    logic [1:0] flt_d_r;
    logic [1:0] flt_rise;
    logic shut_r, shut_nxt;
    logic [1:0] fresp [2];
    logic [3:0] enslot [2];
    logic [3:0] sdslot [2];
    logic [1:0] on_now, off_now, kill;
    logic slot_tick, sleep_on;
    logic [6:0] vsel_c, vimg_c;
    logic [2:0] sb;

    assign fresp[0] = c2_tmo_r[csc_pkg::FRESP_HI:csc_pkg::FRESP_LO];
    assign fresp[1] = c3_tmo_r[csc_pkg::FRESP_HI:csc_pkg::FRESP_LO];
    assign enslot[0] = c2_tmo_r[csc_pkg::ENSLOT_HI:csc_pkg::ENSLOT_LO];
    assign enslot[1] = c3_tmo_r[csc_pkg::ENSLOT_HI:csc_pkg::ENSLOT_LO];
    assign sdslot[0] = c2_tmo_r[csc_pkg::SDSLOT_HI:csc_pkg::SDSLOT_LO];
    assign sdslot[1] = c3_tmo_r[csc_pkg::SDSLOT_HI:csc_pkg::SDSLOT_LO];
    assign flt_rise = {conv3_fault, conv2_fault} & ~flt_d_r;
    assign slot_tick = (tick_r == 16'(csc_pkg::SLOT_CYCLES - 1));

    // Per-converter slot match and fault response decode
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_conv
            always_comb begin
                on_now[g] = 1'b0;
                off_now[g] = 1'b0;
                if (st_r == csc_pkg::ST_UP && slot_tick) begin
                    on_now[g] = (enslot[g] == slot_r) && (enslot[g] != csc_pkg::SLOT_NONE);
                end
                if (st_r == csc_pkg::ST_UP && slot_tick && slot_r == csc_pkg::SLOT_LAST) begin
                    on_now[g] = on_now[g] || (enslot[g] == csc_pkg::SLOT_EDGE);
                end
                if (st_r == csc_pkg::ST_DOWN && slot_tick) begin
                    off_now[g] = (sdslot[g] == slot_r);
                end
                if (st_r == csc_pkg::ST_DOWN && slot_tick && slot_r == csc_pkg::SLOT_LAST) begin
                    off_now[g] = 1'b1;
                end
                kill[g] = flt_rise[g] && fresp[g] == csc_pkg::FR_CONV;
            end
        end
    endgenerate

    // Sequencer: numbered slots ascend from 1 to 14 in each direction
    always_comb begin
        st_nxt = st_r;
        slot_nxt = slot_r;
        tick_nxt = 16'h0000;
        shut_nxt = 1'b0;
        c2_ok_nxt = c2_ok_r;
        c3_ok_nxt = c3_ok_r;
        if (st_r == csc_pkg::ST_UP || st_r == csc_pkg::ST_DOWN) begin
            tick_nxt = slot_tick ? 16'h0000 : tick_r + 16'h0001;
        end
        unique case (st_r)
            csc_pkg::ST_OFF: begin
                if (power_up_req) begin
                    st_nxt = csc_pkg::ST_UP;
                    slot_nxt = csc_pkg::SLOT_FIRST;
                    c2_ok_nxt = 1'b1;
                    c3_ok_nxt = 1'b1;
                end
            end
            csc_pkg::ST_UP: begin
                if (slot_tick) begin
                    if (slot_r == csc_pkg::SLOT_LAST) begin
                        st_nxt = csc_pkg::ST_ACTIVE;
                    end else begin
                        slot_nxt = slot_r + 4'h1;
                    end
                end
            end
            csc_pkg::ST_ACTIVE: begin
                if (power_down_req) begin
                    st_nxt = csc_pkg::ST_DOWN;
                    slot_nxt = csc_pkg::SLOT_FIRST;
                end
            end
            csc_pkg::ST_DOWN: begin
                if (slot_tick) begin
                    if (slot_r == csc_pkg::SLOT_LAST) begin
                        st_nxt = csc_pkg::ST_OFF;
                    end else begin
                        slot_nxt = slot_r + 4'h1;
                    end
                end
            end
            default: begin
                st_nxt = csc_pkg::ST_OFF;
            end
        endcase
        if (kill[0]) c2_ok_nxt = 1'b0;
        if (kill[1]) c3_ok_nxt = 1'b0;
        // Fault with response code 2 or 3 drops the system at once, in any state
        for (int i = 0; i < 2; i++) begin
            if (flt_rise[i] && fresp[i][1]) begin
                shut_nxt = 1'b1;
                st_nxt = csc_pkg::ST_OFF;
                slot_nxt = csc_pkg::SLOT_NONE;
                tick_nxt = 16'h0000;
            end
        end
    end

    always_comb begin
        c2_en_nxt = c2_en_r;
        c3_en_nxt = c3_en_r;
        if (on_now[0]) c2_en_nxt = 1'b1;
        if (on_now[1]) c3_en_nxt = 1'b1;
        if (off_now[0] || kill[0] || shut_nxt) c2_en_nxt = 1'b0;
        if (off_now[1] || kill[1] || shut_nxt) c3_en_nxt = 1'b0;
    end

    // Registers; sm_reset restores the fixed defaults as the state machine does
    always_comb begin
        c2_tmo_nxt = c2_tmo_r;
        c3_ctl_nxt = c3_ctl_r;
        c3_tmo_nxt = c3_tmo_r;
        c3_lp_nxt = c3_lp_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        rdata_nxt = 16'h0000;
        if (wr) begin
            unique case (addr)
                csc_pkg::ADDR_C2_TMO: c2_tmo_nxt = wdata & csc_pkg::C2_TMO_MASK;
                csc_pkg::ADDR_C3_CTL: begin
                    c3_ctl_nxt = wdata & csc_pkg::C3_CTL_MASK;
                    if (wdata[csc_pkg::VSEL_HI:0] > csc_pkg::VSEL_MAX) begin
                        c3_ctl_nxt[csc_pkg::VSEL_HI:0] = csc_pkg::VSEL_MAX;
                    end
                end
                csc_pkg::ADDR_C3_TMO: c3_tmo_nxt = wdata & csc_pkg::C3_TMO_MASK;
                csc_pkg::ADDR_C3_LP: begin
                    c3_lp_nxt = wdata & csc_pkg::C3_LP_MASK;
                    if (wdata[csc_pkg::VSEL_HI:0] > csc_pkg::VSEL_MAX) begin
                        c3_lp_nxt[csc_pkg::VSEL_HI:0] = csc_pkg::VSEL_MAX;
                    end
                end
                csc_pkg::ADDR_STATUS: stat_nxt = stat_r & ~wdata[1:0];
                csc_pkg::ADDR_MASK: mask_nxt = wdata[1:0];
                default: ;
            endcase
        end
        stat_nxt = stat_nxt | flt_rise;
        if (sm_reset) begin
            c2_tmo_nxt = csc_pkg::C2_TMO_RST;
            c3_ctl_nxt = csc_pkg::C3_CTL_RST;
            c3_tmo_nxt = csc_pkg::C3_TMO_RST;
            c3_lp_nxt = csc_pkg::C3_LP_RST;
        end
        if (rd) begin
            unique case (addr)
                csc_pkg::ADDR_C2_TMO: rdata_nxt = c2_tmo_r;
                csc_pkg::ADDR_C3_CTL: rdata_nxt = c3_ctl_r;
                csc_pkg::ADDR_C3_TMO: rdata_nxt = c3_tmo_r;
                csc_pkg::ADDR_C3_LP: rdata_nxt = c3_lp_r;
                csc_pkg::ADDR_STATUS: rdata_nxt = {14'h0000, stat_r};
                csc_pkg::ADDR_MASK: rdata_nxt = {14'h0000, mask_r};
                csc_pkg::ADDR_SEQ: rdata_nxt = {5'h00, c3_en_r, c2_en_r, st_r, slot_r, 2'h0};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            c2_tmo_r <= csc_pkg::C2_TMO_RST;
            c3_ctl_r <= csc_pkg::C3_CTL_RST;
            c3_tmo_r <= csc_pkg::C3_TMO_RST;
            c3_lp_r <= csc_pkg::C3_LP_RST;
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            rdata_r <= 16'h0000;
            st_r <= csc_pkg::ST_OFF;
            slot_r <= 4'h0;
            tick_r <= 16'h0000;
            c2_en_r <= 1'b0;
            c3_en_r <= 1'b0;
            c2_ok_r <= 1'b0;
            c3_ok_r <= 1'b0;
            flt_d_r <= 2'h0;
            shut_r <= 1'b0;
        end else begin
            c2_tmo_r <= c2_tmo_nxt;
            c3_ctl_r <= c3_ctl_nxt;
            c3_tmo_r <= c3_tmo_nxt;
            c3_lp_r <= c3_lp_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            st_r <= st_nxt;
            slot_r <= slot_nxt;
            tick_r <= tick_nxt;
            c2_en_r <= c2_en_nxt;
            c3_en_r <= c3_en_nxt;
            c2_ok_r <= c2_ok_nxt;
            c3_ok_r <= c3_ok_nxt;
            flt_d_r <= {conv3_fault, conv2_fault};
            shut_r <= shut_nxt;
        end
    end

    // Hibernate source and behaviour
    always_comb begin
        unique case (c3_lp_r[csc_pkg::TRIG_HI:csc_pkg::TRIG_LO])
            2'h0: sleep_on = sw_sleep;
            2'h1: sleep_on = low_power_input_1;
            2'h2: sleep_on = low_power_input_2;
            2'h3: sleep_on = low_power_input_3;
        endcase
        sleep_on = sleep_on | gpio_sleep;
        sb = sleep_on ? c3_lp_r[csc_pkg::SLEEP_HI:csc_pkg::SLEEP_LO] : csc_pkg::SB_KEEP;
        vsel_c = c3_ctl_r[csc_pkg::VSEL_HI:0];
        vimg_c = c3_lp_r[csc_pkg::VSEL_HI:0];
        conv3_vout_code = vsel_c;
        conv3_standby = 1'b0;
        conv3_linear = 1'b0;
        conv3_en = c3_en_r && c3_ok_r;
        // Reserved code 110 is treated as no change
        unique case (sb)
            csc_pkg::SB_IMAGE: conv3_vout_code = vimg_c;
            csc_pkg::SB_STBY: conv3_standby = 1'b1;
            csc_pkg::SB_STBY_IMG: begin
                conv3_standby = 1'b1;
                conv3_vout_code = vimg_c;
            end
            csc_pkg::SB_LIN: conv3_linear = 1'b1;
            csc_pkg::SB_LIN_IMG: begin
                conv3_linear = 1'b1;
                conv3_vout_code = vimg_c;
            end
            csc_pkg::SB_OFF: conv3_en = 1'b0;
            default: ;
        endcase
    end

    assign conv2_en = c2_en_r && c2_ok_r;
    assign conv3_discharge = ~conv3_en && ~c3_ctl_r[csc_pkg::FLOAT_BIT];
    assign conv3_ovp_en = ~c3_ctl_r[csc_pkg::OVP_OFF_BIT];
    assign system_shutdown = shut_r;
    assign irq = |(stat_r & mask_r);
    assign rdata = rdata_r;
    assign seq_state = st_r;
endmodule // csc_top

// ===== verif/csc_asserts.sv
`timescale 1ns/1ps
module csc_asserts (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset, active high
    input wire logic power_up_req, // Start-up pulse
    input wire logic [7:0] addr, // Register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic conv2_en, // Converter 2 enable
    input wire logic conv3_en, // Converter 3 enable
    input wire logic conv3_discharge, // Discharge active
    input wire logic conv3_ovp_en, // Protection active
    input wire logic [6:0] conv3_vout_code, // Applied voltage code
    input wire logic conv3_standby, // Standby forced
    input wire logic conv3_linear, // Linear mode forced
    input wire logic system_shutdown, // Shutdown pulse
    input wire logic [2:0] seq_state // Sequencer state
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence ctl_wr_s;
        wr && addr == 8'hBA;
    endsequence
    sequence all_off_s;
        seq_state == 3'h0 && !conv2_en && !conv3_en;
    endsequence
    ovp_off_a: assert property (ctl_wr_s |=> conv3_ovp_en != $past(wdata[11]))
        else $error("protection enable does not follow control bit");
    disch_excl_a: assert property (conv3_en |-> !conv3_discharge)
        else $error("discharge while converter enabled");
    vsel_max_a: assert property (conv3_vout_code <= 7'h66)
        else $error("voltage code above top setting");
    shut_pulse_a: assert property (system_shutdown |=> !system_shutdown)
        else $error("shutdown pulse longer than one cycle");
    shut_off_a: assert property (system_shutdown |-> ##[0:1] all_off_s)
        else $error("system shutdown leaves converters or state on");
    up_start_a: assert property (seq_state == 3'h0 && power_up_req |=> seq_state == 3'h1)
        else $error("start-up request not taken");
    act_entry_a: assert property (seq_state == 3'h2 && seq_state != $past(seq_state)
        |-> $past(seq_state) == 3'h1)
        else $error("active entered other than from start-up");
    c2_rise_a: assert property ($rose(conv2_en) |-> $past(seq_state) == 3'h1)
        else $error("converter 2 enabled outside start-up");
    mode_excl_a: assert property (!(conv3_linear && conv3_standby))
        else $error("standby and linear forced together");
endmodule // csc_asserts
bind csc_top csc_asserts csc_asserts_i (.mclk, .rst, .power_up_req, .addr, .wdata, .wr,
    .conv2_en, .conv3_en, .conv3_discharge, .conv3_ovp_en, .conv3_vout_code,
    .conv3_standby, .conv3_linear, .system_shutdown, .seq_state);

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sm_reset = 1'b0, power_up_req = 1'b0, power_down_req = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic conv2_fault = 1'b0, conv3_fault = 1'b0, sw_sleep = 1'b0, gpio_sleep = 1'b0;
    logic low_power_input_1 = 1'b0, low_power_input_2 = 1'b0, low_power_input_3 = 1'b0;
    logic [15:0] rdata;
    logic conv2_en, conv3_en, conv3_discharge, conv3_ovp_en, conv3_standby, conv3_linear;
    logic system_shutdown, irq;
    logic [6:0] conv3_vout_code;
    logic [2:0] seq_state;
    int n_fail = 0;
    int n_checks = 0;
    csc_top csc_top_i (.mclk, .rst, .sm_reset, .power_up_req, .power_down_req, .addr, .wdata,
        .wr, .rd, .rdata, .conv2_fault, .conv3_fault, .sw_sleep, .low_power_input_1,
        .low_power_input_2, .low_power_input_3, .gpio_sleep, .conv2_en, .conv3_en,
        .conv3_discharge, .conv3_ovp_en, .conv3_vout_code, .conv3_standby, .conv3_linear,
        .system_shutdown, .irq, .seq_state);
    initial forever #5 mclk = ~mclk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Samples 1 ns past the edge so registered outputs have settled
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        repeat (2) tick();
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask
    task automatic wait_st(logic [2:0] st);
        for (int i = 0; i < 3000 && seq_state !== st; i++) tick();
        chk("seq_state", st, seq_state);
        if (seq_state !== st)
            stop_test();
    endtask
    task automatic up();
        @(posedge mclk);
        power_up_req <= 1'b1;
        @(posedge mclk);
        power_up_req <= 1'b0;
        wait_st(3'h2);
    endtask
    task automatic t_regs();
        rd_chk("c2_tmo", 8'hB8, 16'h0000);
        rd_chk("c3_lp", 8'hBC, 16'h0006);
        chk("ovp_rst", 16'h0001, conv3_ovp_en);
        chk("disch_rst", 16'h0001, conv3_discharge);
        wr_reg(8'hBA, 16'hFFFF);
        rd_chk("c3_ctl", 8'hBA, 16'h0C66);
        chk("ovp_en", 16'h0000, conv3_ovp_en);
        chk("discharge", 16'h0000, conv3_discharge);
        wr_reg(8'hBA, 16'h0020);
        chk("discharge", 16'h0001, conv3_discharge);
        chk("vout", 16'h0020, conv3_vout_code);
        rd_chk("unmapped", 8'h10, 16'h0000);
        wr_reg(8'hBA, 16'h0C55);
        @(posedge mclk);
        sm_reset <= 1'b1;
        @(posedge mclk);
        sm_reset <= 1'b0;
        rd_chk("c3_ctl", 8'hBA, 16'h0000);
        chk("ovp_sm", 16'h0001, conv3_ovp_en);
        $display("test regs done");
    endtask
    task automatic t_seq();
        int i;
        wr_reg(8'hB8, 16'h0800);
        wr_reg(8'hBB, 16'h3C40);
        @(posedge mclk);
        power_up_req <= 1'b1;
        @(posedge mclk);
        power_up_req <= 1'b0;
        for (i = 0; i < 2000 && conv2_en !== 1'b1; i++) tick();
        chk("c2_on_time", 16'h0001, i >= 190 && i <= 210);
        chk("c3_early", 16'h0000, conv3_en);
        wait_st(3'h2);
        chk("c3_active", 16'h0001, conv3_en);
        rd_chk("seq_reg", 8'hC2, 16'h06B8);
        @(posedge mclk);
        power_down_req <= 1'b1;
        @(posedge mclk);
        power_down_req <= 1'b0;
        for (i = 0; i < 2000 && conv3_en !== 1'b0; i++) tick();
        chk("c3_off_time", 16'h0001, i >= 90 && i <= 110);
        chk("c2_held", 16'h0001, conv2_en);
        wait_st(3'h0);
        chk("c2_off", 16'h0000, conv2_en);
        $display("test sequence done");
    endtask
    task automatic t_fault();
        logic seen;
        wr_reg(8'hC1, 16'h0003);
        wr_reg(8'hB8, 16'h0000);
        for (int r = 0; r < 4; r++) begin
            wr_reg(8'hBB, {r[1:0], 14'h3C00});
            if (seq_state !== 3'h2)
                up();
            chk("c2_unslotted", 16'h0000, conv2_en);
            @(posedge mclk);
            conv3_fault <= 1'b1;
            seen = 1'b0;
            for (int i = 0; i < 4; i++) begin
                tick();
                seen = seen | system_shutdown;
            end
            chk("irq", 16'h0001, irq);
            rd_chk("status", 8'hC0, 16'h0002);
            chk("shutdown", r[1], seen);
            chk("state", r[1] ? 3'h0 : 3'h2, seq_state);
            chk("c3_en", r == 0, conv3_en);
            @(posedge mclk);
            conv3_fault <= 1'b0;
            wr_reg(8'hC0, 16'h0002);
            chk("irq_clear", 16'h0000, irq);
        end
        wr_reg(8'hC1, 16'h0000);
        @(posedge mclk);
        conv2_fault <= 1'b1;
        repeat (3) tick();
        chk("irq_masked", 16'h0000, irq);
        wr_reg(8'hC1, 16'h0001);
        chk("irq_unmasked", 16'h0001, irq);
        @(posedge mclk);
        conv2_fault <= 1'b0;
        wr_reg(8'hC0, 16'h0001);
        chk("irq_clear", 16'h0000, irq);
        // Clear and a new fault edge in one cycle: the new event must survive
        @(posedge mclk);
        addr <= 8'hC0;
        wdata <= 16'h0001;
        wr <= 1'b1;
        conv2_fault <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        conv2_fault <= 1'b0;
        rd_chk("set_wins", 8'hC0, 16'h0001);
        $display("test fault done");
    endtask
    task automatic t_sleep();
        wr_reg(8'hBB, 16'h3C00);
        wr_reg(8'hBA, 16'h0020);
        if (seq_state !== 3'h2)
            up();
        @(posedge mclk);
        sw_sleep <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'hBC, {1'b0, c[2:0], 12'h006});
            chk("vout", (c == 1 || c == 3 || c == 5) ? 16'h6 : 16'h20, conv3_vout_code);
            chk("standby", c == 2 || c == 3, conv3_standby);
            chk("linear", c == 4 || c == 5, conv3_linear);
            chk("c3_en", c != 7, conv3_en);
        end
        @(posedge mclk);
        sw_sleep <= 1'b0;
        // For each select, the other two inputs are driven high first, then the selected input alone
        for (int t = 1; t < 4; t++) begin
            wr_reg(8'hBC, {4'h2, 2'b00, t[1:0], 8'h06});
            @(posedge mclk);
            {low_power_input_3, low_power_input_2, low_power_input_1} <= ~(3'b001 << (t - 1));
            repeat (3) tick();
            chk("standby_other", 16'h0000, conv3_standby);
            @(posedge mclk);
            {low_power_input_3, low_power_input_2, low_power_input_1} <= 3'b001 << (t - 1);
            repeat (3) tick();
            chk("standby_sel", 16'h0001, conv3_standby);
        end
        @(posedge mclk);
        {low_power_input_3, low_power_input_2, low_power_input_1} <= 3'b000;
        gpio_sleep <= 1'b1;
        repeat (3) tick();
        chk("standby_gpio", 16'h0001, conv3_standby);
        $display("test sleep done");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_seq();
        t_fault();
        t_sleep();
        stop_test();
    end
endmodule // testbench
